// ==== hdl/spf_bitmem.sv ====
`timescale 1ns/100ps
module spf_bitmem #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // Clock
    input wire logic clk_i,
    // Write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic wdata_i,
    // Registered read ports
    input wire logic [AW-1:0] raddr_a_i,
    output logic rdata_a_o,
    input wire logic [AW-1:0] raddr_b_i,
    output logic rdata_b_o
);
    logic mem_reg [DEPTH];

    // No reset: contents are set by the sweep after reset
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_reg[waddr_i] <= wdata_i;
        end
        rdata_a_o <= mem_reg[raddr_a_i];
        rdata_b_o <= mem_reg[raddr_b_i];
    end
endmodule

// ==== hdl/spf_link.sv ====
`timescale 1ns/100ps
module spf_link import spf_pkg::*; (
    // Link clock and resets
    input wire logic link_clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    // Serial data
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_n_o,
    // Byte exchange with the system side
    input wire spf_tx_t tx_i,
    output logic rx_tgl_o,
    output logic [7:0] rx_byte_o
);
    logic [2:0] cnt_reg;
    logic [6:0] sh_reg;
    logic [7:0] tx_sh_reg;

    // ----------------------------------------
    // Receive
    // ----------------------------------------
    // Frame select ends the frame; the link clock may stop afterwards
    always_ff @(posedge link_clk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            cnt_reg <= 3'h0;
            sh_reg <= 7'h00;
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
            sh_reg <= {sh_reg[5:0], si_i};
        end
    end

    // Toggle survives frames so no byte event is lost
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_tgl_o <= 1'b0;
            rx_byte_o <= 8'h00;
        end else if (cnt_reg == 3'h7) begin
            rx_byte_o <= {sh_reg, si_i};
            rx_tgl_o <= ~rx_tgl_o;
        end
    end

    // ----------------------------------------
    // Transmit
    // ----------------------------------------
    // Host must rest the clock between bytes until the answer word settles
    always_ff @(posedge link_clk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_o <= 1'b0;
            so_oe_n_o <= 1'b1;
            tx_sh_reg <= 8'h00;
        end else if (cnt_reg == 3'h0) begin
            so_o <= tx_i.data[7];
            tx_sh_reg <= {tx_i.data[6:0], 1'b0};
            so_oe_n_o <= ~tx_i.en;
        end else begin
            so_o <= tx_sh_reg[7];
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        end
    end
endmodule

// ==== hdl/spf_lock_regs.sv ====
`timescale 1ns/100ps
// Behaviour
// - 64-bit key, all ones; read E7h, program E8h, compare E9h.
// - Lock register read A7h; A6h clears lock bit; 91h sets freeze.
// - Lock bit 0 refuses persistent program/erase; 1 allows them.
// - Clear-lock command freezes all persistent protection bits.
// - Persistent mode: lock bit set to one at power-on and hardware reset.
// - Persistent mode: only reset returns lock bit to one.
// - Password mode: lock bit cleared at power-on and hardware reset.
// - Password mode: only the unlock-key command sets the lock bit.
// - Freeze blocks block-protect, select bits and info row changes; here freeze_reg gates no write.
// - Freeze cleared only by power-on or hardware reset, not soft reset.
// - Freeze zero after power-on; set by 91h; no clear command.
// - Persistent read FCh/E2h, program FDh/E3h, erase all E4h.
// - Persistent read gives 00h protected, FFh unprotected; default FFh.
// - Dynamic read FAh/E0h, write FBh/E1h.
// - Dynamic byte 00h protects, FFh unprotects; volatile, default FFh.
// - Training read 41h, non-volatile program 43h, live write 4Ah.
// - 8-bit stored and live patterns, both 00h; stored copied to live.
// - Live pattern writable anytime; reloads from stored on every reset.
// - Live pattern offered during double-rate read dummy cycles; no such read here, only 41h and training_o give it.
// - Sector protected when persistent or dynamic bit is zero.
// - Unlock compares supplied value with key; match sets lock bit, in password mode only.
// - Mode bits 11 default, 10 persistent, 01 password; 00 fails.
module spf_lock_regs import spf_pkg::*; #(
    parameter int NUM_SECT = 64,
    parameter int IDX_W = 6,
    parameter int SECT_LSB = 16
) (
    // Clocks and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic link_clk_i,
    // Serial link pins
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_n_o,
    // Mode strap and resets
    input wire logic [1:0] mode_lock_i,
    input wire logic hw_reset_i,
    input wire logic soft_reset_i,
    // Sector protection query
    input wire logic [IDX_W-1:0] query_idx_i,
    output logic protect_o,
    // State towards the device
    output logic lock_o,
    output logic freeze_o,
    output logic mode_err_o,
    output logic [7:0] training_o
);
    // ----------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------
    logic rst_s_reg, rst_n_reg;
    logic [3:0] s1_reg, s2_reg, s3_reg, stab_reg;
    logic rx_tgl, tgl_seen_reg, cs_prev_reg;
    logic [7:0] rx_byte;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s_reg <= 1'b1;
            rst_n_reg <= rst_s_reg;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            s1_reg <= SYNC_RST;
            s2_reg <= SYNC_RST;
            s3_reg <= SYNC_RST;
            stab_reg <= SYNC_RST;
            tgl_seen_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
        end else begin
            s1_reg <= {mode_lock_i, rx_tgl, cs_n_i};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            stab_reg <= (s2_reg & s3_reg) | (stab_reg & (s2_reg | s3_reg));
            tgl_seen_reg <= stab_reg[1];
            cs_prev_reg <= stab_reg[0];
        end
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    spf_state_t state_reg;
    spf_tx_t tx_reg;
    logic [7:0] op_reg, nv_reg, live_reg, lock_byte;
    logic [3:0] cnt_reg;
    logic [31:0] addr_reg;
    logic [63:0] data_reg, key_reg;
    logic [1:0] rd_pend_reg, mode_reg;
    logic [IDX_W-1:0] sweep_idx_reg, sect_idx, pers_wa, dyn_wa;
    logic sweep_pers_reg, sweep_dyn_reg, relock_reg, init_reg;
    logic lock_reg, freeze_reg, mode_err_reg, protect_reg;
    logic byte_ev, frame_end, exec, unlock_ok, relock_done, sweep_last, is_read;
    logic pers_we, pers_wd, dyn_we, dyn_wd;
    logic pers_q, dyn_q, pers_qry, dyn_qry;

    assign byte_ev = stab_reg[1] != tgl_seen_reg;
    assign frame_end = stab_reg[0] && !cs_prev_reg;
    assign sect_idx = addr_reg[SECT_LSB +: IDX_W];
    assign sweep_last = sweep_idx_reg == IDX_W'(NUM_SECT - 1);
    assign exec = state_reg == ST_BODY && frame_end && cnt_reg >= need_len(op_reg);
    assign is_read = op_reg == OP_READ_PERS || op_reg == OP_READ_PERS4
        || op_reg == OP_READ_DYN || op_reg == OP_READ_DYN4;
    // In password mode only a matching key raises the lock bit
    assign unlock_ok = exec && op_reg == OP_UNLOCK && mode_reg == MODE_PASSWORD
        && data_reg == key_reg;
    assign relock_done = state_reg == ST_SWEEP && sweep_last && relock_reg;

    always_comb begin
        lock_byte = 8'h00;
        lock_byte[LOCK_BIT] = lock_reg;
        lock_byte[FREEZE_BIT] = freeze_reg;
    end

    // ----------------------------------------
    // Link and protection arrays
    // ----------------------------------------
    spf_link u_link (
        .link_clk_i(link_clk_i),
        .rst_n_i(rst_n_reg),
        .cs_n_i(cs_n_i),
        .si_i(si_i),
        .so_o(so_o),
        .so_oe_n_o(so_oe_n_o),
        .tx_i(tx_reg),
        .rx_tgl_o(rx_tgl),
        .rx_byte_o(rx_byte)
    );

    spf_bitmem #(.DEPTH(NUM_SECT), .AW(IDX_W)) u_pers (
        .clk_i(sys_clk_i),
        .we_i(pers_we),
        .waddr_i(pers_wa),
        .wdata_i(pers_wd),
        .raddr_a_i(sect_idx),
        .rdata_a_o(pers_q),
        .raddr_b_i(query_idx_i),
        .rdata_b_o(pers_qry)
    );

    spf_bitmem #(.DEPTH(NUM_SECT), .AW(IDX_W)) u_dyn (
        .clk_i(sys_clk_i),
        .we_i(dyn_we),
        .waddr_i(dyn_wa),
        .wdata_i(dyn_wd),
        .raddr_a_i(sect_idx),
        .rdata_a_o(dyn_q),
        .raddr_b_i(query_idx_i),
        .rdata_b_o(dyn_qry)
    );

    // Sweep writes ones (unprotected); commands write single sectors
    always_comb begin
        pers_we = 1'b0;
        pers_wd = 1'b1;
        pers_wa = sweep_idx_reg;
        dyn_we = 1'b0;
        dyn_wd = 1'b1;
        dyn_wa = sweep_idx_reg;
        if (state_reg == ST_SWEEP) begin
            pers_we = sweep_pers_reg;
            dyn_we = sweep_dyn_reg;
        end else if (exec) begin
            pers_wa = sect_idx;
            dyn_wa = sect_idx;
            pers_we = lock_reg && (op_reg == OP_PROG_PERS || op_reg == OP_PROG_PERS4);
            pers_wd = 1'b0;
            dyn_we = op_reg == OP_WRITE_DYN || op_reg == OP_WRITE_DYN4;
            dyn_wd = &data_reg[63:56];
        end
    end

    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_SWEEP;
            op_reg <= 8'h00;
            cnt_reg <= 4'h0;
            addr_reg <= 32'h0;
            data_reg <= 64'h0;
            tx_reg <= '0;
            rd_pend_reg <= 2'h0;
            sweep_idx_reg <= '0;
            sweep_pers_reg <= 1'b1;
            sweep_dyn_reg <= 1'b1;
            relock_reg <= 1'b1;
            init_reg <= 1'b1;
        end else if (hw_reset_i) begin
            state_reg <= ST_SWEEP;
            tx_reg <= '0;
            rd_pend_reg <= 2'h0;
            sweep_idx_reg <= '0;
            sweep_pers_reg <= 1'b0;
            sweep_dyn_reg <= 1'b1;
            relock_reg <= 1'b1;
        end else begin
            rd_pend_reg <= {rd_pend_reg[0], 1'b0};
            case (state_reg)
                ST_SWEEP: begin
                    sweep_idx_reg <= sweep_idx_reg + 1'b1;
                    if (sweep_last) begin
                        sweep_idx_reg <= '0;
                        sweep_pers_reg <= 1'b0;
                        sweep_dyn_reg <= 1'b0;
                        relock_reg <= 1'b0;
                        init_reg <= 1'b0;
                        // Mid-frame bytes are dropped until the frame ends
                        state_reg <= stab_reg[0] ? ST_OPC : ST_SKIP;
                    end
                end
                ST_SKIP: begin
                    if (frame_end) begin
                        state_reg <= ST_OPC;
                    end
                end
                ST_OPC: begin
                    if (byte_ev) begin
                        op_reg <= rx_byte;
                        cnt_reg <= 4'h0;
                        addr_reg <= 32'h0;
                        data_reg <= {key_reg[7:0], key_reg[63:8]};
                        state_reg <= ST_BODY;
                        case (rx_byte)
                            OP_READ_LOCK: tx_reg <= '{lock_byte, 1'b1};
                            OP_READ_TRAIN: tx_reg <= '{live_reg, 1'b1};
                            OP_READ_KEY: tx_reg <= '{key_reg[7:0], 1'b1};
                            default: tx_reg <= '0;
                        endcase
                    end
                end
                ST_BODY: begin
                    if (rd_pend_reg[1]) begin
                        tx_reg.en <= 1'b1;
                        if (op_reg == OP_READ_DYN || op_reg == OP_READ_DYN4) begin
                            tx_reg.data <= dyn_q ? PROT_OFF : PROT_ON;
                        end else begin
                            tx_reg.data <= pers_q ? PROT_OFF : PROT_ON;
                        end
                    end
                    if (frame_end) begin
                        tx_reg <= '0;
                        state_reg <= ST_OPC;
                        if (exec && op_reg == OP_ERASE_PERS && lock_reg) begin
                            state_reg <= ST_SWEEP;
                            sweep_pers_reg <= 1'b1;
                        end
                    end else if (byte_ev) begin
                        if (cnt_reg != 4'hF) begin
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                        if (cnt_reg < addr_len(op_reg)) begin
                            addr_reg <= {addr_reg[23:0], rx_byte};
                            if (is_read && cnt_reg == addr_len(op_reg) - 4'h1) begin
                                rd_pend_reg <= {rd_pend_reg[0], 1'b1};
                            end
                        end else if (op_reg == OP_READ_KEY) begin
                            tx_reg.data <= data_reg[7:0];
                            data_reg <= {data_reg[7:0], data_reg[63:8]};
                        end else begin
                            data_reg <= {rx_byte, data_reg[63:8]};
                        end
                    end
                end
                default: state_reg <= ST_OPC;
            endcase
        end
    end

    // ----------------------------------------
    // Lock, freeze, key, mode, training
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            lock_reg <= 1'b0;
        end else if (relock_done) begin
            lock_reg <= mode_reg != MODE_PASSWORD;
        end else if (unlock_ok) begin
            lock_reg <= 1'b1;
        end else if (exec && op_reg == OP_CLEAR_LOCK) begin
            lock_reg <= 1'b0;
        end
    end

    // Soft reset deliberately has no path here
    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            freeze_reg <= 1'b0;
        end else if (hw_reset_i) begin
            freeze_reg <= 1'b0;
        end else if (exec && op_reg == OP_SET_FREEZE) begin
            freeze_reg <= 1'b1;
        end
    end

    // One-time programmable: bits only fall
    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            key_reg <= KEY_RST;
        end else if (exec && op_reg == OP_PROG_KEY && lock_reg) begin
            key_reg <= key_reg & data_reg;
        end
    end

    // Mode strap is caught while the power-on sweep runs
    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            mode_reg <= MODE_DEFAULT;
            mode_err_reg <= 1'b0;
        end else if (state_reg == ST_SWEEP && init_reg) begin
            mode_reg <= stab_reg[3:2];
            mode_err_reg <= stab_reg[3:2] == MODE_ILLEGAL;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            nv_reg <= TRAIN_RST;
            live_reg <= TRAIN_RST;
        end else if (hw_reset_i || soft_reset_i) begin
            live_reg <= nv_reg;
        end else if (exec && op_reg == OP_PROG_TRAIN) begin
            nv_reg <= data_reg[63:56];
            live_reg <= data_reg[63:56];
        end else if (exec && op_reg == OP_WRITE_TRAIN) begin
            live_reg <= data_reg[63:56];
        end
    end

    // Arrays hold garbage until the first sweep completes
    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            protect_reg <= 1'b1;
        end else if (!init_reg) begin
            protect_reg <= !(pers_qry && dyn_qry);
        end
    end

    assign protect_o = protect_reg;
    assign lock_o = lock_reg;
    assign freeze_o = freeze_reg;
    assign mode_err_o = mode_err_reg;
    assign training_o = live_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_reg);

    property p_freeze_sticky;
        $fell(freeze_reg) |-> $past(hw_reset_i);
    endproperty
    a_freeze_sticky: assert property (p_freeze_sticky) else $error("freeze fell");

    property p_soft_keeps_freeze;
        soft_reset_i && !hw_reset_i && freeze_reg |=> freeze_reg;
    endproperty
    a_soft_keeps_freeze: assert property (p_soft_keeps_freeze) else $error("soft reset");

    property p_lock_rise;
        $rose(lock_reg) |-> $past(unlock_ok) || $past(relock_done);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock rose");

    property p_pw_lock;
        mode_reg == MODE_PASSWORD && $rose(lock_reg) |-> $past(unlock_ok);
    endproperty
    a_pw_lock: assert property (p_pw_lock) else $error("password lock");

    property p_relock;
        relock_done |=> lock_reg == (mode_reg != MODE_PASSWORD);
    endproperty
    a_relock: assert property (p_relock) else $error("reset lock");

    property p_pers_guard;
        pers_we && state_reg != ST_SWEEP |-> lock_reg && !pers_wd;
    endproperty
    a_pers_guard: assert property (p_pers_guard) else $error("pers write");

    property p_bad_unlock;
        exec && op_reg == OP_UNLOCK && data_reg != key_reg && !hw_reset_i |=> $stable(lock_reg);
    endproperty
    a_bad_unlock: assert property (p_bad_unlock) else $error("bad unlock");

    property p_key_otp;
        ##1 (key_reg & ~$past(key_reg)) == 64'h0;
    endproperty
    a_key_otp: assert property (p_key_otp) else $error("key bit rose");

    property p_live_reload;
        soft_reset_i || hw_reset_i |=> live_reg == $past(nv_reg);
    endproperty
    a_live_reload: assert property (p_live_reload) else $error("reload");

    property p_read_value;
        rd_pend_reg[1] && state_reg == ST_BODY && !frame_end && !hw_reset_i
            |=> tx_reg.data == PROT_ON || tx_reg.data == PROT_OFF;
    endproperty
    a_read_value: assert property (p_read_value) else $error("read value");

    c_unlock: cover property (unlock_ok);
    c_erase: cover property (exec && op_reg == OP_ERASE_PERS && lock_reg);
    c_freeze: cover property ($rose(freeze_reg));
    c_key_read: cover property (state_reg == ST_BODY && op_reg == OP_READ_KEY && byte_ev);
endmodule

// ==== hdl/spf_pkg.sv ====
package spf_pkg;

    // ----------------------------------------
    // Command opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_READ_KEY = 8'hE7;
    localparam logic [7:0] OP_PROG_KEY = 8'hE8;
    localparam logic [7:0] OP_UNLOCK = 8'hE9;
    localparam logic [7:0] OP_READ_LOCK = 8'hA7;
    localparam logic [7:0] OP_CLEAR_LOCK = 8'hA6;
    localparam logic [7:0] OP_SET_FREEZE = 8'h91;
    localparam logic [7:0] OP_READ_PERS = 8'hFC;
    localparam logic [7:0] OP_READ_PERS4 = 8'hE2;
    localparam logic [7:0] OP_PROG_PERS = 8'hFD;
    localparam logic [7:0] OP_PROG_PERS4 = 8'hE3;
    localparam logic [7:0] OP_ERASE_PERS = 8'hE4;
    localparam logic [7:0] OP_READ_DYN = 8'hFA;
    localparam logic [7:0] OP_READ_DYN4 = 8'hE0;
    localparam logic [7:0] OP_WRITE_DYN = 8'hFB;
    localparam logic [7:0] OP_WRITE_DYN4 = 8'hE1;
    localparam logic [7:0] OP_READ_TRAIN = 8'h41;
    localparam logic [7:0] OP_PROG_TRAIN = 8'h43;
    localparam logic [7:0] OP_WRITE_TRAIN = 8'h4A;

    // ----------------------------------------
    // Fields, reset values, byte counts
    // ----------------------------------------
    localparam logic [63:0] KEY_RST = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [7:0] PROT_ON = 8'h00;
    localparam logic [7:0] PROT_OFF = 8'hFF;
    localparam logic [7:0] TRAIN_RST = 8'h00;
    localparam int LOCK_BIT = 0;
    localparam int FREEZE_BIT = 7;
    localparam logic [1:0] MODE_DEFAULT = 2'h3;
    localparam logic [1:0] MODE_PERSIST = 2'h2;
    localparam logic [1:0] MODE_PASSWORD = 2'h1;
    localparam logic [1:0] MODE_ILLEGAL = 2'h0;
    localparam logic [3:0] SYNC_RST = 4'hD;
    localparam logic [3:0] LEN_A3 = 4'h3;
    localparam logic [3:0] LEN_A4 = 4'h4;
    localparam logic [3:0] LEN_KEY = 4'h8;
    localparam logic [3:0] LEN_BYTE = 4'h1;

    typedef enum logic [1:0] {
        ST_OPC = 2'b00,
        ST_BODY = 2'b01,
        ST_SWEEP = 2'b10,
        ST_SKIP = 2'b11
    } spf_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic en;
    } spf_tx_t;

    function automatic logic [3:0] addr_len(input logic [7:0] op);
        case (op)
            OP_READ_PERS, OP_PROG_PERS, OP_READ_DYN, OP_WRITE_DYN: addr_len = LEN_A3;
            OP_READ_PERS4, OP_PROG_PERS4, OP_READ_DYN4, OP_WRITE_DYN4: addr_len = LEN_A4;
            default: addr_len = 4'h0;
        endcase
    endfunction

    function automatic logic [3:0] need_len(input logic [7:0] op);
        case (op)
            OP_PROG_KEY, OP_UNLOCK: need_len = LEN_KEY;
            OP_WRITE_DYN, OP_WRITE_DYN4, OP_PROG_TRAIN, OP_WRITE_TRAIN: begin
                need_len = addr_len(op) + LEN_BYTE;
            end
            default: need_len = addr_len(op);
        endcase
    endfunction

endpackage

// ==== verif/spf_host.sv ====
`timescale 1ns/100ps
module spf_host (
    // Link pins
    output logic link_clk_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i
);
    // ----------------------------------------
    // Frame driver, clock still between frames
    // ----------------------------------------
    initial begin
        link_clk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    task automatic frame(input logic [79:0] v, input int n, output logic [7:0] r);
        cs_n_o = 1'b0;
        #23;
        for (int i = n * 8 - 1; i >= 0; i--) begin
            si_o = v[i];
            #16 link_clk_o = 1'b1;
            #16 link_clk_o = 1'b0;
            r = {r[6:0], so_i};
            // Clock rests between bytes so the answer can cross domains
            if (i % 8 == 0) begin
                #128;
            end
        end
        #120 cs_n_o = 1'b1;
        // Released line toggles, never holds old bit
        si_o = ~si_o;
        #120;
    endtask
endmodule

// ==== verif/tb_spf_lock_regs.sv ====
`timescale 1ns/100ps
module tb_spf_lock_regs import spf_pkg::*;;
    logic sys_clk_i = 1'b0, reset_n_i = 1'b0, hw = 1'b0, sw = 1'b0;
    logic lclk, cs_n, si, so, so_oe_n, prot, lock, frz, merr;
    logic [1:0] mode = 2'h3;
    logic [2:0] qidx = 3'h0;
    logic [7:0] trn, rx;
    int errors = 0, samples_checked = 0;
    // ----------------------------------------
    // Small sector count keeps sweeps short
    // ----------------------------------------
    spf_lock_regs #(.NUM_SECT(8), .IDX_W(3), .SECT_LSB(16)) i_dut (.sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i), .link_clk_i(lclk), .cs_n_i(cs_n), .si_i(si), .so_o(so),
        .so_oe_n_o(so_oe_n), .mode_lock_i(mode), .hw_reset_i(hw), .soft_reset_i(sw),
        .query_idx_i(qidx), .protect_o(prot), .lock_o(lock), .freeze_o(frz),
        .mode_err_o(merr), .training_o(trn));
    spf_host i_host (.link_clk_o(lclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    initial begin
        #200000;
        errors++;
        results;
    end
    task automatic results;
        $display("errors %0d checks %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (exp !== got) begin
            errors++;
            $display("Error %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic tx(input logic [79:0] v, input int n);
        i_host.frame(v, n, rx);
    endtask
    task automatic por;
        reset_n_i = 1'b0;
        step(4);
        reset_n_i = 1'b1;
        step(20);
    endtask
    task automatic kick(input logic h);
        step(1);
        hw = h;
        sw = !h;
        step(1);
        hw = 1'b0;
        sw = 1'b0;
        step(20);
    endtask
    task automatic q(input logic [2:0] idx, input logic e);
        step(1);
        qidx = idx;
        step(3);
        chk({7'h0, prot}, {7'h0, e});
    endtask
    task automatic t_default;
        chk({7'h0, lock}, 8'h01);
        chk({6'h0, merr, frz}, 8'h00);
        chk(trn, TRAIN_RST);
        tx(80'hA700, 2);
        chk(rx, 8'h01);
        chk({7'h0, so_oe_n}, 8'h01);
        tx(80'hFC0300000000, 6);
        chk(rx, PROT_OFF);
    endtask
    task automatic t_protect;
        tx(80'hFB01000000, 5);
        q(3'h1, 1'b1);
        q(3'h0, 1'b0);
        tx(80'hFD020000, 4);
        tx(80'hE2000200000000, 7);
        chk(rx, PROT_ON);
        q(3'h2, 1'b1);
        tx(80'hA6, 1);
        chk({7'h0, lock}, 8'h00);
        tx(80'hFD030000, 4);
        tx(80'hE4, 1);
        tx(80'hFC0300000000, 6);
        chk(rx, PROT_OFF);
        tx(80'hFC0200000000, 6);
        chk(rx, PROT_ON);
    endtask
    task automatic t_freeze;
        tx(80'h91, 1);
        chk({7'h0, frz}, 8'h01);
        tx(80'hE9FFFFFFFFFFFFFFFF, 9);
        chk({7'h0, lock}, 8'h00);
        kick(1'b0);
        chk({7'h0, frz}, 8'h01);
        kick(1'b1);
        chk({frz, 6'h0, lock}, 8'h01);
        q(3'h1, 1'b0);
    endtask
    task automatic t_train;
        tx(80'h4A5A, 2);
        chk(trn, 8'h5A);
        kick(1'b0);
        chk(trn, TRAIN_RST);
        tx(80'h433C, 2);
        tx(80'h4A11, 2);
        kick(1'b1);
        chk(trn, 8'h3C);
        tx(80'h4100, 2);
        chk(rx, 8'h3C);
    endtask
    task automatic t_mode;
        mode = 2'h0;
        por;
        chk({6'h0, merr, lock}, 8'h03);
    endtask
    task automatic t_pass;
        mode = 2'h1;
        por;
        chk({7'h0, lock}, 8'h00);
        tx(80'hE90000000000000000, 9);
        chk({7'h0, lock}, 8'h00);
        tx(80'hE9FFFFFFFFFFFFFFFF, 9);
        chk({7'h0, lock}, 8'h01);
        tx(80'hFD040000, 4);
        tx(80'hFC0400000000, 6);
        chk(rx, PROT_ON);
        tx(80'hE4, 1);
        tx(80'hFC0400000000, 6);
        chk(rx, PROT_OFF);
        tx(80'hE700, 2);
        chk(rx, KEY_RST[7:0]);
        tx(80'hE85AFFFFFFFFFFFFFF, 9);
        tx(80'hE700, 2);
        chk(rx, 8'h5A);
    endtask
    initial begin
        por;
        t_default;
        t_protect;
        t_freeze;
        t_train;
        t_mode;
        t_pass;
        results;
    end
endmodule
